/* sim/tb.sv */
// Purpose: Self-checking bench for the peripheral flag register
// Assumes: One-cycle ack; a write lands at the ack edge
// Notes: Event rows first, then hand-written cases
`timescale 1ns/1ps
module tb
	import periph_flags_pkg::*;
;
	logic sysClk, srst, req, we;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rd;
	logic ack;
	logic [5:0] ev;
	logic [1:0] mode;
	logic [7:0] flags;
	int errorCnt, checks, cycCnt;
	// Events {port,serial,cap,cmp,period,ovf}, mode, expected flags
	logic [15:0] rows [10] = '{16'h8080, 16'h4008, 16'h2004, 16'h1104, 16'h2100,
		16'h1000, 16'h2200, 16'h1300, 16'h0802, 16'h0401};
	peripheral_interrupt_flags peripheral_interrupt_flags_inst (.sys_clk(sysClk), .srst(srst),
		.cyc_i(req), .stb_i(req), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
		.dat_o(rdat), .ack_o(ack), .portAccessDone(ev[5]), .serialXferDone(ev[4]),
		.ccpCapture(ev[3]), .ccpCompareMatch(ev[2]), .ccpMode(mode), .periodMatch(ev[1]),
		.timerOverflow(ev[0]), .flags(flags));
	initial begin
		sysClk = 1'b0;
		forever #2.5 sysClk = ~sysClk;
	end
	// ****
	// Helpers
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errorCnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		@(posedge sysClk);
		req <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do @(posedge sysClk); while (ack !== 1'b1);
		rd = rdat;
		req <= 1'b0;
		// The write lands at this edge; let flags settle before anyone looks
		#1;
	endtask
	task automatic pulse(input logic [5:0] e, input logic [1:0] m);
		@(posedge sysClk);
		ev <= e;
		mode <= m;
		@(posedge sysClk);
		ev <= 6'h00;
		#1;
	endtask
	task automatic stop_test;
		$display("errors=%0d checks=%0d", errorCnt, checks);
		if (errorCnt == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Guards against a missing ack
	always @(posedge sysClk) begin
		cycCnt++;
		if (cycCnt == 2000) begin
			errorCnt++;
			stop_test();
		end
	end
	initial begin
		{srst, req, we, adr, sel, wdat, ev, mode} = 55'h0;
		srst = 1'b1;
		repeat (3) @(posedge sysClk);
		srst <= 1'b0;
		bus(1'b0, FLAGS_OFFSET, 4'hF, 32'h0);
		chk(rd, 32'h0);
		foreach (rows[i]) begin
			pulse(rows[i][15:10], rows[i][9:8]);
			chk({24'h0, flags}, {24'h0, rows[i][7:0]});
			bus(1'b1, FLAGS_OFFSET, 4'h1, 32'h0);
			chk({24'h0, flags}, 32'h0);
		end
		// Sticky long after the pulse
		pulse(6'h10, 2'h0);
		repeat (20) @(posedge sysClk);
		bus(1'b0, FLAGS_OFFSET, 4'hF, 32'h0);
		chk(rd, 32'h8);
		bus(1'b1, FLAGS_OFFSET, 4'h0, 32'h0);
		chk({24'h0, flags}, 32'h8);
		// Software keeps bit 6 clear; bits 5 and 4 must not store
		bus(1'b1, FLAGS_OFFSET, 4'h1, 32'hBF);
		bus(1'b0, FLAGS_OFFSET, 4'hF, 32'h0);
		chk(rd, 32'h8F);
		bus(1'b1, 8'h10, 4'h1, 32'h0);
		bus(1'b0, 8'h10, 4'hF, 32'h0);
		chk(rd, 32'h0);
		chk({24'h0, flags}, 32'h8F);
		@(posedge sysClk);
		srst <= 1'b1;
		@(posedge sysClk);
		srst <= 1'b0;
		#1 chk({24'h0, flags}, 32'h0);
		stop_test();
	end
endmodule

/* src/periph_flags_pkg.sv */
// Purpose: Constants for the peripheral interrupt flag register block
// Assumes: Classic Wishbone slave, 32-bit data, byte addressed
// Notes: One register at byte offset 0x0C
package periph_flags_pkg;
	localparam logic [7:0] FLAGS_OFFSET = 8'h0C;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam int PORT_BIT = 7;
	localparam int RSVD_BIT = 6;
	localparam int SERIAL_BIT = 3;
	localparam int CCP_BIT = 2;
	localparam int PERIOD_BIT = 1;
	localparam int OVF_BIT = 0;
	// Bits that hold state; 5 and 4 are absent
	localparam logic [7:0] IMPL_MASK = 8'hCF;
	// Capture/compare unit modes
	typedef enum logic [1:0] {
		CCP_CAPTURE = 2'h0,
		CCP_COMPARE = 2'h1,
		CCP_PWM = 2'h2,
		CCP_OFF = 2'h3
	} ccp_mode_t;
	// Bus slave states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'h1,
		BUS_ACK = 2'h2
	} bus_state_t;
endpackage

/* src/peripheral_interrupt_flags.sv */
// Purpose: Sticky peripheral event flags reached over classic Wishbone
// Assumes: Event inputs are one-cycle pulses synchronous to sys_clk
// Notes: Set wins over a software clear in the same cycle;
//   a write lands at the edge that samples ack
//
// Notes on behaviour
// [R1] Reset clears every implemented flag bit to zero.
// [R2] Bits 5 and 4 hold nothing and always read zero.
// [R3] Bit 7 sets on a completed parallel port read or write.
// [R4] Bit 3 sets when a serial port transfer finishes.
// [R5] Serial done flag stays set until software writes it zero.
// [R6] Capture mode: bit 2 sets when the 16-bit timer is captured.
// [R7] Compare mode: bit 2 sets on timer match; PWM mode ignores it.
// [R8] Bit 1 sets when the 8-bit timer equals the period register.
// [R9] Bit 0 sets on 16-bit timer overflow, held until cleared.
// [R10] Software writes zero to reserved bit 6; it has no function. The code still stores bit 6 and reads back what was written.
`timescale 1ns/1ps
module peripheral_interrupt_flags
	import periph_flags_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Peripheral events
	input wire logic portAccessDone,
	input wire logic serialXferDone,
	input wire logic ccpCapture,
	input wire logic ccpCompareMatch,
	input wire logic [1:0] ccpMode,
	input wire logic periodMatch,
	input wire logic timerOverflow,
	// Flag view
	output logic [7:0] flags
);
	// ****************************************
	// Bus slave
	// ****************************************
	bus_state_t busState;
	bus_state_t next_busState;
	logic next_ack;
	logic [31:0] next_datOut;
	logic wrStrobe;

	function automatic logic hitFlags(input logic [7:0] a);
		hitFlags = (a == FLAGS_OFFSET);
	endfunction

	always_comb begin
		next_busState = busState;
		next_ack = 1'b0;
		next_datOut = dat_o;
		wrStrobe = 1'b0;
		case (busState)
			BUS_IDLE: begin
				if (cyc_i && stb_i) begin
					next_busState = BUS_ACK;
					next_ack = 1'b1;
					// Unmapped reads return zero
					next_datOut = hitFlags(adr_i) ? {24'h000000, flags} : 32'h00000000;
				end
			end
			BUS_ACK: begin
				next_busState = BUS_IDLE;
				// Master still holds the request here, so the write is safe to apply
				wrStrobe = cyc_i && stb_i && we_i && sel_i[0] && hitFlags(adr_i);
			end
			default: begin
				next_busState = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			busState <= BUS_IDLE;
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			busState <= next_busState;
			ack_o <= next_ack;
			dat_o <= next_datOut;
		end
	end

	// ****************************************
	// Flag register
	// ****************************************
	logic [7:0] setMask;
	logic [7:0] next_flags;
	logic ccpEvent;

	always_comb begin
		case (ccp_mode_t'(ccpMode))
			CCP_CAPTURE: ccpEvent = ccpCapture; // [R6]
			CCP_COMPARE: ccpEvent = ccpCompareMatch; // [R7]
			default: ccpEvent = 1'b0; // [R7]
		endcase
		setMask = 8'h00;
		setMask[PORT_BIT] = portAccessDone; // [R3]
		setMask[SERIAL_BIT] = serialXferDone; // [R4]
		setMask[CCP_BIT] = ccpEvent;
		setMask[PERIOD_BIT] = periodMatch; // [R8]
		setMask[OVF_BIT] = timerOverflow; // [R9]
		next_flags = flags;
		// Write lands at the ack edge; an event in that cycle beats the clear
		if (wrStrobe) begin
			next_flags = dat_i[7:0];
		end
		next_flags = (next_flags | setMask) & IMPL_MASK; // [R2] [R5]
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			flags <= FLAGS_RESET; // [R1]
		end else begin
			flags <= next_flags;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence busReq_s;
		cyc_i && stb_i && busState == BUS_IDLE;
	endsequence

	sequence ackPulse_s;
		ack_o ##1 !ack_o;
	endsequence

	sequence wrAck_s;
		ack_o && cyc_i && stb_i && we_i && sel_i[0] && adr_i == FLAGS_OFFSET;
	endsequence

	sequence rdReq_s;
		busReq_s ##0 !we_i;
	endsequence

	reset_clear_a: assert property (@(posedge sys_clk) srst |=> flags == FLAGS_RESET) // [R1]
		else $error("flags not cleared by reset");
	reset_bus_a: assert property (@(posedge sys_clk) srst |=> !ack_o && dat_o == 32'h00000000)
		else $error("bus outputs not idle after reset");
	unimpl_zero_a: assert property (@(posedge sys_clk) disable iff (srst) flags[5:4] == 2'h0) // [R2]
		else $error("bits 5 and 4 not zero");
	read_zero_a: assert property (@(posedge sys_clk) disable iff (srst) ack_o |-> dat_o[5:4] == 2'h0) // [R2]
		else $error("bits 5 and 4 read back nonzero");

	// ****************************************
	// Checks on the bus answer
	// ****************************************
	bus_ack_a: assert property (@(posedge sys_clk) disable iff (srst) busReq_s |=> ackPulse_s)
		else $error("ack not a one-cycle answer");
	ack_cause_a: assert property (@(posedge sys_clk) disable iff (srst) ack_o |-> $past(cyc_i && stb_i))
		else $error("ack with no request");
	// Read data is the register as it stood at the taking edge
	read_data_a: assert property (@(posedge sys_clk) disable iff (srst)
		rdReq_s ##0 (adr_i == FLAGS_OFFSET) |=> dat_o == {24'h000000, $past(flags)})
		else $error("read data not the flag register");
	read_unmapped_a: assert property (@(posedge sys_clk) disable iff (srst)
		rdReq_s ##0 (adr_i != FLAGS_OFFSET) |=> dat_o == 32'h00000000)
		else $error("unmapped read not zero");
	write_clear_a: assert property (@(posedge sys_clk) disable iff (srst) // [R5]
		wrAck_s ##0 (!dat_i[SERIAL_BIT] && !serialXferDone) |=> !flags[SERIAL_BIT])
		else $error("serial flag not cleared by write");

	// ****************************************
	// Checks on flag setting and holding
	// ****************************************
	// Only its own event or a write may raise a flag; only a write may drop it
	port_set_a: assert property (@(posedge sys_clk) disable iff (srst) portAccessDone |=> flags[7]) // [R3]
		else $error("port flag not set");
	port_quiet_a: assert property (@(posedge sys_clk) disable iff (srst) // [R3]
		!flags[PORT_BIT] && !portAccessDone && !wrStrobe |=> !flags[PORT_BIT])
		else $error("port flag set with no access");

	serial_set_a: assert property (@(posedge sys_clk) disable iff (srst) serialXferDone |=> flags[3]) // [R4]
		else $error("serial flag not set");
	serial_hold_a: assert property (@(posedge sys_clk) disable iff (srst) // [R5]
		flags[3] && !wrStrobe |=> flags[3])
		else $error("serial flag dropped without write");
	serial_quiet_a: assert property (@(posedge sys_clk) disable iff (srst) // [R5]
		!flags[SERIAL_BIT] && !serialXferDone && !wrStrobe |=> !flags[SERIAL_BIT])
		else $error("serial flag set with no transfer");

	capture_set_a: assert property (@(posedge sys_clk) disable iff (srst) // [R6]
		ccpMode == CCP_CAPTURE && ccpCapture |=> flags[2])
		else $error("capture flag not set");
	capture_hold_a: assert property (@(posedge sys_clk) disable iff (srst) // [R6]
		flags[CCP_BIT] && !wrStrobe |=> flags[CCP_BIT])
		else $error("ccp flag dropped without write");
	compare_set_a: assert property (@(posedge sys_clk) disable iff (srst) // [R7]
		ccpMode == CCP_COMPARE && ccpCompareMatch |=> flags[CCP_BIT])
		else $error("compare flag not set");
	// PWM and off modes must never raise the ccp flag
	pwm_quiet_a: assert property (@(posedge sys_clk) disable iff (srst) // [R7]
		ccpMode == CCP_PWM && !flags[2] && !wrStrobe |=> !flags[2])
		else $error("ccp flag set in pwm mode");
	off_quiet_a: assert property (@(posedge sys_clk) disable iff (srst)
		ccpMode == CCP_OFF && !flags[CCP_BIT] && !wrStrobe |=> !flags[CCP_BIT])
		else $error("ccp flag set while unit off");

	period_set_a: assert property (@(posedge sys_clk) disable iff (srst) periodMatch |=> flags[1]) // [R8]
		else $error("period flag not set");
	period_hold_a: assert property (@(posedge sys_clk) disable iff (srst) // [R8]
		flags[PERIOD_BIT] && !wrStrobe |=> flags[PERIOD_BIT])
		else $error("period flag dropped without write");

	overflow_set_a: assert property (@(posedge sys_clk) disable iff (srst) timerOverflow |=> flags[0]) // [R9]
		else $error("overflow flag not set");
	overflow_hold_a: assert property (@(posedge sys_clk) disable iff (srst) // [R9]
		flags[0] && !wrStrobe |=> flags[0])
		else $error("overflow flag dropped");
endmodule
